// ### hw/pflash_prot_pkg.sv
/*
 * constants shared by the program flash protection block: register bit
 * positions, address windows, reset-load states and the port address map.
 * assumes a single 100 MHz clock and a plain strobe register port.
 */
// Notes on behaviour
// - in normal single-chip mode a software write is kept only if protection does not shrink.
// - in special single-chip mode writes skip the shrink check; size fields still need their disable bit set.
// - during reset the register is loaded from the stored protection byte at 0xFF_FE0C.
// - a double-bit fault on that load clears operation enable and sets all other bits.
// - program or erase aimed at a protected address raises the protection violation flag.
// - block erase is refused whenever any sector of the block is protected.
// - with operation enable clear the disable bits select unprotected ranges.
// - with operation enable set the disable bits enable protected ranges.
// - the low disable bit governs a region starting at 0xFF_8000, 0 enables it.
// - high size 00, 01, 10 give 2, 4, 8 KB ending at the top of flash.
// - a size field is writable only while its disable bit is set.
// - the three control bits decode to eight functions, 111 none and 011 full.
package pflash_prot_pkg;

	// ---- register bits ----
	localparam int OPEN_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int HDIS_BIT = 5;
	localparam int HS_MSB = 4;
	localparam int HS_LSB = 3;
	localparam int LDIS_BIT = 2;
	localparam int LS_MSB = 1;
	localparam int LS_LSB = 0;
	localparam logic [7:0] PROT_WMASK = 8'hBF;
	// fault value: open clear, all else set (full protection)
	localparam logic [7:0] PROT_FAULT_VAL = 8'h7F;
	localparam logic [7:0] PROT_RESET_VAL = 8'h7F;

	// ---- address windows ----
	localparam logic [23:0] PROT_BYTE_ADDR = 24'hFF_FE0C;
	localparam logic [23:0] LOW_BASE_ADDR = 24'hFF_8000;
	localparam logic [23:0] FLASH_TOP_ADDR = 24'hFF_FFFF;
	localparam logic [23:0] SIZE_1K = 24'h00_0400;
	localparam logic [23:0] SIZE_2K = 24'h00_0800;
	localparam logic [23:0] BLOCK_SIZE = 24'h02_0000;
	localparam logic [23:0] SECTOR_SIZE = 24'h00_0200;

	// ---- register port map ----
	localparam logic [3:0] ADDR_PROT = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_LAST = 4'h3;
	localparam int ST_VIOL_BIT = 0;
	localparam int ST_REFUSE_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam logic [2:0] MASK_RESET_VAL = 3'h0;

	// ---- commands from the flash controller ----
	localparam logic [1:0] CMD_PROGRAM = 2'h1;
	localparam logic [1:0] CMD_SECTOR_ERASE = 2'h2;
	localparam logic [1:0] CMD_BLOCK_ERASE = 2'h3;

	typedef enum logic [2:0] {
		LD_IDLE = 3'b001,
		LD_WAIT = 3'b010,
		LD_DONE = 3'b100
	} load_state_t;

endpackage

// ### hw/pflash_range_check.sv
/*
 * checks one address range against the protection settings.
 * assumes settings stable while the address is checked.
 */
`timescale 1ns/100ps
module pflash_range_check
	import pflash_prot_pkg::*;
(
	// settings
	input wire logic [7:0] prot_i,
	// query range
	input wire logic [23:0] lo_addr_i,
	input wire logic [23:0] hi_addr_i,
	// verdict
	output logic any_prot_o
);
	logic [23:0] hi_start;
	logic [23:0] lo_end;
	logic in_hi_a;
	logic in_lo_a;
	logic in_lo_b;
	logic open_bit;
	logic hit_hi;
	logic hit_lo;

	always_comb begin
		case (prot_i[HS_MSB:HS_LSB])
			2'b00: hi_start = FLASH_TOP_ADDR - SIZE_2K + 24'h00_0001;
			2'b01: hi_start = FLASH_TOP_ADDR - (SIZE_2K << 1) + 24'h00_0001;
			default: hi_start = FLASH_TOP_ADDR - (SIZE_2K << 2) + 24'h00_0001;
		endcase
	end

	// low region from base, size by field (1 KB steps doubling)
	always_comb begin
		case (prot_i[LS_MSB:LS_LSB])
			2'b00: lo_end = LOW_BASE_ADDR + SIZE_1K - 24'h00_0001;
			2'b01: lo_end = LOW_BASE_ADDR + (SIZE_1K << 1) - 24'h00_0001;
			2'b10: lo_end = LOW_BASE_ADDR + (SIZE_1K << 2) - 24'h00_0001;
			default: lo_end = LOW_BASE_ADDR + (SIZE_1K << 3) - 24'h00_0001;
		endcase
	end

	// range overlap: any byte of the query inside a region
	// the high region ends at the top address, so its upper bound always holds
	assign in_hi_a = (hi_addr_i >= hi_start);
	assign in_lo_a = (hi_addr_i >= LOW_BASE_ADDR);
	assign in_lo_b = (lo_addr_i <= lo_end);
	assign hit_hi = in_hi_a & ~prot_i[HDIS_BIT];
	assign hit_lo = in_lo_a & in_lo_b & ~prot_i[LDIS_BIT];
	assign open_bit = prot_i[OPEN_BIT];

	always_comb begin
		if (open_bit) begin
			any_prot_o = hit_hi | hit_lo;
		end else begin
			// protected unless wholly inside an enabled unprotected window
			any_prot_o = ~((hit_hi & (lo_addr_i >= hi_start)) | (hit_lo & (hi_addr_i <= lo_end)
				& (lo_addr_i >= LOW_BASE_ADDR)));
		end
	end
endmodule

// ### hw/pflash_shrink_check.sv
/*
 * decides whether a proposed protection value covers at least the current.
 * assumes both values are settled in the same cycle.
 */
`timescale 1ns/100ps
module pflash_shrink_check
	import pflash_prot_pkg::*;
(
	// current and proposed
	input wire logic [7:0] cur_i,
	input wire logic [7:0] new_i,
	// verdict
	output logic grow_ok_o
);
	logic same_open;
	logic hi_ok;
	logic lo_ok;

	assign same_open = (cur_i[OPEN_BIT] == new_i[OPEN_BIT]);
	always_comb begin
		if (cur_i[OPEN_BIT]) begin
			// protected ranges: may enable a range or widen it
			hi_ok = cur_i[HDIS_BIT] ? 1'b1 : (~new_i[HDIS_BIT]
				& (new_i[HS_MSB:HS_LSB] >= cur_i[HS_MSB:HS_LSB]));
			lo_ok = cur_i[LDIS_BIT] ? 1'b1 : (~new_i[LDIS_BIT]
				& (new_i[LS_MSB:LS_LSB] >= cur_i[LS_MSB:LS_LSB]));
		end else begin
			// unprotected ranges: may close a range or narrow it
			hi_ok = new_i[HDIS_BIT] ? 1'b1 : (~cur_i[HDIS_BIT]
				& (new_i[HS_MSB:HS_LSB] <= cur_i[HS_MSB:HS_LSB]));
			lo_ok = new_i[LDIS_BIT] ? 1'b1 : (~cur_i[LDIS_BIT]
				& (new_i[LS_MSB:LS_LSB] <= cur_i[LS_MSB:LS_LSB]));
		end
		// dropping to open clear from set is allowed only as full protection
		if (!same_open) begin
			grow_ok_o = cur_i[OPEN_BIT] & new_i[HDIS_BIT] & new_i[LDIS_BIT];
		end else begin
			grow_ok_o = hi_ok & lo_ok;
		end
	end
endmodule

// ### hw/pflash_protection.sv
/*
 * program flash protection register with reset load, write checking,
 * command screening and sticky event flags.
 * assumes the flash controller presents one command per strobe and that
 * the reset read of the protection byte returns within its own time.
 */
`timescale 1ns/100ps
module pflash_protection
	import pflash_prot_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	// mode
	input wire logic SPECIAL_MODE_I,
	// reset-sequence load of the protection byte
	output logic NVM_RD_O,
	output logic [23:0] NVM_ADDR_O,
	input wire logic NVM_VALID_I,
	input wire logic [7:0] NVM_DATA_I,
	input wire logic NVM_DBL_FAULT_I,
	// command screening
	input wire logic CMD_VALID_I,
	input wire logic [1:0] CMD_KIND_I,
	input wire logic [23:0] CMD_ADDR_I,
	output logic CMD_ALLOW_O,
	output logic CMD_VIOL_O,
	// register port
	input wire logic [3:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// status
	output logic LOAD_DONE_O,
	output logic IRQ_O
);
	import pflash_prot_pkg::*;

	//----------------------------------------------------------------
	// declarations
	//----------------------------------------------------------------
	load_state_t ld_reg;
	load_state_t ld_next;
	logic [7:0] prot_reg;
	logic [7:0] prot_wr_val;
	logic [2:0] status_reg;
	logic [2:0] mask_reg;
	logic [23:0] q_lo;
	logic [23:0] q_hi;
	logic any_prot;
	logic grow_ok;
	logic wr_prot;
	logic wr_status;
	logic wr_mask;
	logic ev_viol;
	logic ev_refuse;
	logic ev_fault;
	logic cmd_bad;
	logic sw_wr_ok;

	//----------------------------------------------------------------
	// reset-sequence load
	//----------------------------------------------------------------
	// state change of the load sequencer; one read after reset release
	always_comb begin
		case (ld_reg)
			LD_IDLE: ld_next = LD_WAIT;
			LD_WAIT: ld_next = NVM_VALID_I ? LD_DONE : LD_WAIT;
			LD_DONE: ld_next = LD_DONE;
			default: ld_next = LD_IDLE;
		endcase
	end

	// sequencer state
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			ld_reg <= LD_IDLE;
		end else begin
			ld_reg <= ld_next;
		end
	end

	// read request toward the array
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			NVM_RD_O <= 1'b0;
			NVM_ADDR_O <= 24'h00_0000;
			LOAD_DONE_O <= 1'b0;
		end else begin
			NVM_RD_O <= (ld_next == LD_WAIT);
			NVM_ADDR_O <= PROT_BYTE_ADDR;
			LOAD_DONE_O <= (ld_next == LD_DONE);
		end
	end

	//----------------------------------------------------------------
	// software write checking
	//----------------------------------------------------------------
	// size fields held unless their disable bit is set
	always_comb begin
		prot_wr_val = (REG_WDATA_I & PROT_WMASK) | (prot_reg & ~PROT_WMASK);
		if (!prot_reg[HDIS_BIT]) begin
			prot_wr_val[HS_MSB:HS_LSB] = prot_reg[HS_MSB:HS_LSB];
		end
		if (!prot_reg[LDIS_BIT]) begin
			prot_wr_val[LS_MSB:LS_LSB] = prot_reg[LS_MSB:LS_LSB];
		end
	end

	pflash_shrink_check u_shrink (
		.cur_i(prot_reg),
		.new_i(prot_wr_val),
		.grow_ok_o(grow_ok)
	);

	assign sw_wr_ok = SPECIAL_MODE_I | grow_ok;

	assign wr_prot = REG_WR_I & (REG_ADDR_I == ADDR_PROT) & (ld_reg == LD_DONE);
	assign wr_status = REG_WR_I & (REG_ADDR_I == ADDR_STATUS);
	assign wr_mask = REG_WR_I & (REG_ADDR_I == ADDR_MASK);

	// protection register: reset load then checked writes
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			prot_reg <= PROT_RESET_VAL;
		end else if (ld_reg == LD_WAIT && NVM_VALID_I) begin
			if (NVM_DBL_FAULT_I) begin
				prot_reg <= PROT_FAULT_VAL;
			end else begin
				prot_reg <= NVM_DATA_I;
			end
		end else if (wr_prot && sw_wr_ok) begin
			prot_reg <= prot_wr_val;
		end
	end

	//----------------------------------------------------------------
	// command screening
	//----------------------------------------------------------------
	// query span: the address for program, its sector for sector erase, the whole block for block erase
	always_comb begin
		if (CMD_KIND_I == CMD_BLOCK_ERASE) begin
			q_lo = CMD_ADDR_I & ~(BLOCK_SIZE - 24'h00_0001);
			q_hi = q_lo + BLOCK_SIZE - 24'h00_0001;
		end else if (CMD_KIND_I == CMD_SECTOR_ERASE) begin
			q_lo = CMD_ADDR_I & ~(SECTOR_SIZE - 24'h00_0001);
			q_hi = q_lo + SECTOR_SIZE - 24'h00_0001;
		end else begin
			q_lo = CMD_ADDR_I;
			q_hi = CMD_ADDR_I;
		end
	end

	pflash_range_check u_range (
		.prot_i(prot_reg),
		.lo_addr_i(q_lo),
		.hi_addr_i(q_hi),
		.any_prot_o(any_prot)
	);

	assign cmd_bad = CMD_VALID_I & (CMD_KIND_I != 2'h0) & any_prot;

	// verdict registered one cycle after the command strobe
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			CMD_ALLOW_O <= 1'b0;
			CMD_VIOL_O <= 1'b0;
		end else begin
			CMD_ALLOW_O <= CMD_VALID_I & ~cmd_bad;
			CMD_VIOL_O <= cmd_bad;
		end
	end

	//----------------------------------------------------------------
	// events and interrupt
	//----------------------------------------------------------------
	assign ev_viol = cmd_bad;
	assign ev_refuse = wr_prot & ~sw_wr_ok;
	assign ev_fault = (ld_reg == LD_WAIT) & NVM_VALID_I & NVM_DBL_FAULT_I;

	// sticky flags, write one clears; a new event wins over the clear
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			status_reg <= 3'h0;
		end else begin
			status_reg <= (status_reg & ~(wr_status ? REG_WDATA_I[2:0] : 3'h0))
				| {ev_fault, ev_refuse, ev_viol};
		end
	end

	// interrupt mask
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			mask_reg <= MASK_RESET_VAL;
		end else if (wr_mask) begin
			mask_reg <= REG_WDATA_I[2:0];
		end
	end

	// level interrupt registered so it comes from a flip-flop
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(status_reg & mask_reg);
		end
	end

	//----------------------------------------------------------------
	// register read
	//----------------------------------------------------------------
	// read data valid the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				ADDR_PROT: REG_RDATA_O <= prot_reg & PROT_WMASK;
				ADDR_STATUS: REG_RDATA_O <= {5'h00, status_reg};
				ADDR_MASK: REG_RDATA_O <= {5'h00, mask_reg};
				default: REG_RDATA_O <= 8'h00;
			endcase
		end else begin
			REG_RDATA_O <= 8'h00;
		end
	end
endmodule

// ### dv/pflash_protection_properties.sv
/*
 * port-level assertions and covers for the protection block.
 * assumes bind to the top module, one clock, synchronous reset.
 */
`timescale 1ns/100ps
module pflash_protection_properties
	import pflash_prot_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	// reset load
	input wire logic NVM_RD_O,
	input wire logic [23:0] NVM_ADDR_O,
	input wire logic NVM_VALID_I,
	input wire logic NVM_DBL_FAULT_I,
	// command screen
	input wire logic CMD_VALID_I,
	input wire logic [1:0] CMD_KIND_I,
	input wire logic CMD_ALLOW_O,
	input wire logic CMD_VIOL_O,
	// register port and status
	input wire logic [3:0] REG_ADDR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	input wire logic LOAD_DONE_O,
	input wire logic IRQ_O
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);
	property p_cmd_answer;
		CMD_VALID_I |=> $onehot({CMD_ALLOW_O, CMD_VIOL_O});
	endproperty
	a_cmd_answer: assert property (p_cmd_answer) else $error("no single answer");
	property p_cmd_quiet;
		!CMD_VALID_I |=> !CMD_ALLOW_O && !CMD_VIOL_O;
	endproperty
	a_cmd_quiet: assert property (p_cmd_quiet) else $error("answer without command");
	property p_kind_none;
		CMD_VALID_I && CMD_KIND_I == 2'h0 |-> ##1 CMD_ALLOW_O;
	endproperty
	a_kind_none: assert property (p_kind_none) else $error("empty command refused");
	property p_load_addr;
		NVM_RD_O |-> NVM_ADDR_O == PROT_BYTE_ADDR;
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("wrong load address");
	property p_load_done;
		NVM_RD_O && NVM_VALID_I |=> LOAD_DONE_O;
	endproperty
	a_load_done: assert property (p_load_done) else $error("load not finished");
	property p_load_wait;
		NVM_RD_O && !NVM_VALID_I |=> NVM_RD_O && !LOAD_DONE_O;
	endproperty
	a_load_wait: assert property (p_load_wait) else $error("load ended early");
	property p_rdata_idle;
		!REG_RD_I |=> REG_RDATA_O == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
	property p_reserved;
		REG_RD_I && REG_ADDR_I == ADDR_PROT |=> !REG_RDATA_O[RSVD_BIT];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	// main scenarios reached
	c_viol: cover property (CMD_VALID_I && CMD_KIND_I == CMD_BLOCK_ERASE ##1 CMD_VIOL_O);
	c_fault: cover property (NVM_RD_O && NVM_VALID_I && NVM_DBL_FAULT_I);
	c_irq: cover property ($rose(IRQ_O));
endmodule

// ### dv/pflash_nvm_model.sv
/*
 * stand-in for the flash array during the reset read of the stored byte.
 * assumes the bench sets byte, fault and delay before reset ends.
 */
`timescale 1ns/100ps
module pflash_nvm_model
	import pflash_prot_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// read request
	input wire logic rd_i,
	input wire logic [23:0] addr_i,
	// bench settings
	input wire logic [7:0] byte_i,
	input wire logic fault_i,
	input wire logic [3:0] dly_i,
	// answer
	output logic valid_o,
	output logic [7:0] data_o,
	output logic fault_o
);
	logic [3:0] cnt_reg;
	logic sent_reg;
	// answer once
	// idle data toggles so a stale byte is never mistaken for the answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 4'h0;
			sent_reg <= 1'b0;
			valid_o <= 1'b0;
			fault_o <= 1'b0;
			data_o <= ~byte_i;
		end else begin
			valid_o <= 1'b0;
			fault_o <= 1'b0;
			data_o <= ~data_o;
			if (rd_i && !sent_reg) begin
				if (cnt_reg == dly_i) begin
					valid_o <= 1'b1;
					fault_o <= fault_i;
					data_o <= (addr_i == PROT_BYTE_ADDR) ? byte_i : ~byte_i;
					sent_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
		end
	end
endmodule

// ### dv/pflash_protection_tb.sv
/*
 * self-checking bench for the protection block.
 * assumes the nvm model and the property checker compile alongside.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module pflash_protection_tb;
	import pflash_prot_pkg::*;
	logic REF_CLK_I = 1'b0, SRST_I = 1'b0, SPECIAL_MODE_I = 1'b0, NVM_RD_O, NVM_VALID_I;
	logic NVM_DBL_FAULT_I, CMD_VALID_I = 1'b0, CMD_ALLOW_O, CMD_VIOL_O, REG_WR_I = 1'b0;
	logic REG_RD_I = 1'b0, LOAD_DONE_O, IRQ_O, nv_fault = 1'b0;
	logic [1:0] CMD_KIND_I = 2'h0, k;
	logic [3:0] REG_ADDR_I = 4'h0, nv_dly = 4'h5;
	logic [7:0] REG_WDATA_I = 8'h00, NVM_DATA_I, REG_RDATA_O, nv_byte = 8'hFF, cur, q, r;
	logic [23:0] NVM_ADDR_O, CMD_ADDR_I = 24'h00_0000, a;
	logic [23:0] corner [5] = '{24'hFF_8000, 24'hFF_83FF, 24'hFF_F7FF, 24'hFF_FFFF, 24'hFC_0100};
	int n_mismatch = 0, checks = 0;
	// ----------------------------------------
	// design, far side and clock
	// ----------------------------------------
	pflash_protection u_dut (.*);
	pflash_nvm_model u_nvm (.clk_i(REF_CLK_I), .rst_i(SRST_I), .rd_i(NVM_RD_O),
		.addr_i(NVM_ADDR_O), .byte_i(nv_byte), .fault_i(nv_fault), .dly_i(nv_dly),
		.valid_o(NVM_VALID_I), .data_o(NVM_DATA_I), .fault_o(NVM_DBL_FAULT_I));
	always #5 REF_CLK_I = ~REF_CLK_I;
	// expected violation from the current setting
	function automatic logic ev(logic [7:0] p, logic [1:0] c, logic [23:0] x);
		logic [23:0] hs, ls;
		logic hit;
		if (c == 2'h0) return 1'b0;
		if (c == CMD_SECTOR_ERASE) x[8:0] = 9'h000;
		if (c == CMD_BLOCK_ERASE) return (x[23:17] == 7'h7F) ? (!p[7] || !p[5] || !p[2]) : !p[7];
		hs = SIZE_2K << ((p[4:3] == 2'b11) ? 2'd2 : p[4:3]);
		ls = SIZE_1K << p[1:0];
		hit = (!p[5] && x > FLASH_TOP_ADDR - hs) || (!p[2] && x >= LOW_BASE_ADDR && x < LOW_BASE_ADDR + ls);
		return p[7] ? hit : !hit;
	endfunction
	task automatic print_verdict();
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge REF_CLK_I);
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= ad;
		REG_WDATA_I <= d;
		@(posedge REF_CLK_I);
		REG_WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		@(posedge REF_CLK_I);
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= ad;
		@(posedge REF_CLK_I);
		REG_RD_I <= 1'b0;
		#1 `CHK(REG_RDATA_O, e)
	endtask
	task automatic cmd(input logic [1:0] c, input logic [23:0] x, input logic e);
		@(posedge REF_CLK_I);
		CMD_VALID_I <= 1'b1;
		CMD_KIND_I <= c;
		CMD_ADDR_I <= x;
		@(posedge REF_CLK_I);
		CMD_VALID_I <= 1'b0;
		#1 `CHK({CMD_VIOL_O, CMD_ALLOW_O}, {e, !e})
	endtask
	// reset then bounded wait for the stored byte
	task automatic reset_load();
		int n;
		SRST_I <= 1'b1;
		repeat (20) @(posedge REF_CLK_I);
		SRST_I <= 1'b0;
		for (n = 0; n < 100 && LOAD_DONE_O !== 1'b1; n++) @(posedge REF_CLK_I);
		`CHK(LOAD_DONE_O, 1'b1)
	endtask
	// watchdog, far beyond the several hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge REF_CLK_I);
		n_mismatch++;
		print_verdict();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		r = 8'($urandom(7125));
		reset_load();
		rd(ADDR_PROT, 8'hBF);
		cur = 8'hBF;
		SPECIAL_MODE_I <= 1'b1;
		// every function code twice, random sizes and commands
		for (int i = 0; i < 16; i++) begin
			r = 8'($urandom());
			q = {i[2], r[6], i[1], r[4:3], i[0], r[1:0]};
			wr(ADDR_PROT, cur | 8'h24);
			wr(ADDR_PROT, q | 8'h24);
			wr(ADDR_PROT, q);
			cur = q & PROT_WMASK;
			rd(ADDR_PROT, cur);
			for (int j = 0; j < 9; j++) begin
				k = 2'($urandom());
				a = (j < 5) ? corner[j] : (24'hFF_8000 | 24'($urandom() & 32'h7FFF));
				cmd(k, a, ev(cur, k, a));
			end
		end
		wr(ADDR_PROT, 8'h80);
		wr(ADDR_PROT, 8'h9B);
		rd(ADDR_PROT, 8'h80);
		wr(ADDR_STATUS, 8'h07);
		rd(ADDR_STATUS, 8'h00);
		cmd(CMD_PROGRAM, 24'hFF_FFFF, 1'b1);
		rd(ADDR_STATUS, 8'h01);
		`CHK(IRQ_O, 1'b0)
		wr(ADDR_MASK, 8'h01);
		repeat (2) @(posedge REF_CLK_I);
		#1 `CHK(IRQ_O, 1'b1)
		wr(ADDR_STATUS, 8'h01);
		repeat (2) @(posedge REF_CLK_I);
		#1 `CHK(IRQ_O, 1'b0)
		rd(4'hF, 8'h00);
		rd(ADDR_MASK, 8'h01);
		// disable both protected ranges, then rewrite the stored byte
		wr(ADDR_PROT, 8'hA4);
		rd(ADDR_PROT, 8'hA4);
		cmd(CMD_PROGRAM, PROT_BYTE_ADDR, 1'b0);
		nv_byte <= 8'h80;
		reset_load();
		rd(ADDR_PROT, 8'h80);
		@(posedge REF_CLK_I);
		SPECIAL_MODE_I <= 1'b0;
		wr(ADDR_PROT, 8'hA4);
		rd(ADDR_PROT, 8'h80);
		rd(ADDR_STATUS, 8'h02);
		wr(ADDR_PROT, 8'h64);
		rd(ADDR_PROT, 8'h24);
		cmd(CMD_BLOCK_ERASE, 24'hFC_0000, 1'b1);
		nv_fault <= 1'b1;
		nv_dly <= 4'h0;
		reset_load();
		rd(ADDR_PROT, PROT_FAULT_VAL & PROT_WMASK);
		rd(ADDR_STATUS, 8'h04);
		print_verdict();
	end
endmodule
bind pflash_protection pflash_protection_properties u_props (.REF_CLK_I, .SRST_I,
	.NVM_RD_O, .NVM_ADDR_O, .NVM_VALID_I, .NVM_DBL_FAULT_I, .CMD_VALID_I, .CMD_KIND_I,
	.CMD_ALLOW_O, .CMD_VIOL_O, .REG_ADDR_I, .REG_RD_I, .REG_RDATA_O, .LOAD_DONE_O, .IRQ_O);
